/* logic/tcsr_params.svh */
// Offsets, field positions, write masks, reset values and counts of the config/status bank
`ifndef TCSR_PARAMS_SVH
`define TCSR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (six-bit host address)
// ----------------------------------------------------------------------------
`define TCSR_ADDR_W 6
`define TCSR_OFF_CFG0 6'h01
`define TCSR_OFF_CFG1 6'h02
`define TCSR_OFF_CFG2 6'h03
`define TCSR_OFF_RFST 6'h04
`define TCSR_OFF_CHST 6'h05

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TCSR_CFG0_SILENT_BIT 7
`define TCSR_CFG0_LEVEL_HI 6
`define TCSR_CFG0_LEVEL_LO 4
`define TCSR_CFG0_ARBIT_BIT 3
`define TCSR_CFG0_SADDR_HI 2
`define TCSR_CFG0_SADDR_LO 0
`define TCSR_CFG1_KEEPCRC_BIT 7
`define TCSR_CFG1_VREG_HI 6
`define TCSR_CFG1_VREG_LO 2
`define TCSR_CFG1_RREG_HI 1
`define TCSR_CFG1_RREG_LO 0
`define TCSR_CFG2_PASS_BIT 6
`define TCSR_CFG2_EXT_BIT 5
`define TCSR_CFG2_POWM_HI 1
`define TCSR_CFG2_POWM_LO 0
`define TCSR_RFST_FIELD_BIT 7
`define TCSR_RFST_STATE_HI 6
`define TCSR_RFST_STATE_LO 3
`define TCSR_RFST_NOTVALID_BIT 2
`define TCSR_CHST_MEMSIZE_BIT 7
`define TCSR_CHST_BUSKIND_BIT 6
`define TCSR_CHST_KILL_HI 5
`define TCSR_CHST_KILL_LO 4
`define TCSR_CHST_AUTHLOCK_BIT 3

// ----------------------------------------------------------------------------
// Host write masks and read masks (1 = bit takes host data / bit is defined)
// ----------------------------------------------------------------------------
`define TCSR_CFG0_WMASK 8'h08
`define TCSR_CFG1_WMASK 8'h00
`define TCSR_CFG2_WMASK 8'h63
`define TCSR_RFST_RMASK 8'hFC
`define TCSR_CHST_RMASK 8'hF8

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define TCSR_RST_BYTE 8'h00
`define TCSR_RST_STATE 4'h0
`define TCSR_UNMAPPED_DATA 8'h00
`define TCSR_SYNC_STAGES 2
`define TCSR_AUTH_W 3
`define TCSR_AUTH_LIMIT 7

// ----------------------------------------------------------------------------
// Tag state codes
// ----------------------------------------------------------------------------
`define TCSR_TS_POWER_OFF 4'h0
`define TCSR_TS_SENSE 4'h1
`define TCSR_TS_RESOLUTION 4'h3
`define TCSR_TS_RESOLUTION_L2 4'h2
`define TCSR_TS_SELECTED 4'h6
`define TCSR_TS_SECTOR_TWO 4'h7
`define TCSR_TS_SLEEP 4'h9
`define TCSR_TS_SLEEP_SENSE 4'hB
`define TCSR_TS_SLEEP_SENSE_L2 4'hA
`define TCSR_TS_SLEEP_SELECTED 4'hE
`define TCSR_TS_SLEEP_SECTOR_TWO 4'hF

`endif

/* logic/tcsr_pkg.sv */
// Types shared by the tag config/status register bank
package tcsr_pkg;

   // ----------------------------------------------------------------------------
   // Host register request, one cycle
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic rd;
      logic wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } tcsr_host_req_t;

   // ----------------------------------------------------------------------------
   // Configuration bytes as held in the bank and in the EEPROM block
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] cfg_byte_zero;
      logic [7:0] cfg_byte_one;
      logic [7:0] cfg_byte_two;
   } tcsr_cfg_t;

   // ----------------------------------------------------------------------------
   // Image delivered by the EEPROM reader at initialization
   // ----------------------------------------------------------------------------
   typedef struct packed {
      tcsr_cfg_t cfg;
      logic [1:0] chipkill;
      logic mem_size_flag;
      logic bus_kind_flag;
   } tcsr_eeprom_t;

   // Load sequencing of the bank
   typedef enum logic {TCSR_ST_WAIT, TCSR_ST_RUN} tcsr_load_t;

endpackage

/* logic/tcsr_sync.sv */
// Two-stage synchroniser for pin-level inputs
`include "tcsr_params.svh"
module tcsr_sync
   import tcsr_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out_r
);

   logic [WIDTH-1:0] meta_r;

   // Refuse a width the register stages cannot hold
   if (WIDTH < 1)
      $error("tcsr_sync: WIDTH must be at least 1");

   // First stage feeds only the second stage
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_r <= '0;
         sync_out_r <= '0;
      end
      else
      begin
         meta_r <= async_in;
         sync_out_r <= meta_r;
      end
   end

endmodule

/* logic/tcsr_rf_status.sv */
// RF status byte: field presence, tag state and update flag
`include "tcsr_params.svh"
module tcsr_rf_status
   import tcsr_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic field_present_s,
   input wire logic [3:0] tag_state,
   input wire logic tag_state_upd,
   output logic [7:0] rf_status_r
);

   // Field flag, state hold and update flag; reserved bits stay zero
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         rf_status_r <= `TCSR_RST_BYTE;
      else
      begin
         rf_status_r[`TCSR_RFST_FIELD_BIT] <= field_present_s;
         rf_status_r[`TCSR_RFST_NOTVALID_BIT] <= tag_state_upd;
         if (!tag_state_upd)
            rf_status_r[`TCSR_RFST_STATE_HI:`TCSR_RFST_STATE_LO] <= tag_state;
         rf_status_r[1:0] <= 2'h0;
      end
   end

endmodule

/* logic/tcsr_regs.sv */
// Configuration and status register bank of the dynamic tag
//
// Contract
// - cfg0 bit7 shows silent mode, read-only
// - cfg0 bits6:4 read-only silent voltage level
// - cfg0 bit3 writable, RF wins EEPROM access
// - cfg0 bits2:0 read-only slave address bits
// - config defaults load from EEPROM block
// - cfg1 bit7 shows frame check kept
// - cfg1 bits6:2 read-only regulator voltage code
// - cfg1 bits1:0 read-only regulator resistance code
// - cfg2 mirrors byte; bits6,5,1:0 writable
// - rf status bit7 shows field present
// - rf status bits6:3 hold tag state
// - rf status bit2 flags state updating
// - memory size, bus kind flags read-only
// - disable flags reset zero, load from EEPROM
// - bit3 zero at reset, shows auth lock
// - six-bit addresses; status registers read-only
// - set-default restores all but bus kind
`include "tcsr_params.svh"
module tcsr_regs
   import tcsr_pkg::*;
#(
   parameter int AUTH_W = `TCSR_AUTH_W,
   parameter int AUTH_LIMIT = `TCSR_AUTH_LIMIT
)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire tcsr_host_req_t host_req,
   output logic [7:0] host_rdata_r,
   output logic host_rvalid_r,
   input wire logic ee_load,
   input wire tcsr_eeprom_t ee_image,
   input wire logic set_default,
   input wire logic field_present,
   input wire logic [3:0] tag_state,
   input wire logic tag_state_upd,
   input wire logic [AUTH_W-1:0] auth_fail_counter,
   output tcsr_cfg_t cfg_r,
   output logic [7:0] rf_status_r,
   output logic [7:0] chip_status_r,
   output logic loaded_r
);

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   localparam logic [AUTH_W-1:0] AUTH_LIMIT_V = AUTH_LIMIT[AUTH_W-1:0];

   tcsr_load_t load_st_r;
   tcsr_cfg_t cfg_copy_r;
   tcsr_eeprom_t image_hold_r;
   logic field_present_s;
   logic wr_ok;
   logic [7:0] rdata_nxt;
   logic [1:0] chip_prod_r;
   logic [1:0] chip_kill_r;
   logic [3:0] chip_low_r;

   // Refuse parameter values the lock compare cannot serve
   if (AUTH_W < 1 || AUTH_W > 16)
      $error("tcsr_regs: AUTH_W out of range");
   if (AUTH_LIMIT < 1 || AUTH_LIMIT >= (1 << AUTH_W))
      $error("tcsr_regs: AUTH_LIMIT does not fit AUTH_W");

   // ----------------------------------------------------------------------------
   // Pin synchroniser and RF status byte
   // ----------------------------------------------------------------------------
   tcsr_sync #(.WIDTH(1)) u_field_sync (
      .clock(clock),
      .reset_n(reset_n),
      .async_in(field_present),
      .sync_out_r(field_present_s)
   );

   tcsr_rf_status u_rf_status (
      .clock(clock),
      .reset_n(reset_n),
      .field_present_s(field_present_s),
      .tag_state(tag_state),
      .tag_state_upd(tag_state_upd),
      .rf_status_r(rf_status_r)
   );

   // ----------------------------------------------------------------------------
   // Load sequencing
   // ----------------------------------------------------------------------------

   // Wait for the EEPROM image before serving host writes
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         load_st_r <= TCSR_ST_WAIT;
      else
      begin
         case (load_st_r)
            TCSR_ST_WAIT:
            begin
               if (ee_load)
                  load_st_r <= TCSR_ST_RUN;
            end
            TCSR_ST_RUN:
               load_st_r <= TCSR_ST_RUN;
            default:
               load_st_r <= TCSR_ST_WAIT;
         endcase
      end
   end

   // Loaded flag for the outside
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         loaded_r <= 1'b0;
      else if (ee_load)
         loaded_r <= 1'b1;
   end

   // Keep the EEPROM image so that set-default can restore power-up values
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cfg_copy_r <= '0;
         image_hold_r <= '0;
      end
      else if (ee_load)
      begin
         cfg_copy_r <= ee_image.cfg;
         image_hold_r <= ee_image;
      end
   end

   // Host writes only once loaded and when no load or restore is under way
   assign wr_ok = host_req.wr && (load_st_r == TCSR_ST_RUN) && !ee_load && !set_default;

   // ----------------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------------

   // Load and restore win over host writes; only masked bits take host data
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         cfg_r <= '0;
      else if (ee_load)
         cfg_r <= ee_image.cfg;
      else if (set_default)
         cfg_r <= cfg_copy_r;
      else if (wr_ok)
      begin
         case (host_req.addr)
            `TCSR_OFF_CFG0:
               cfg_r.cfg_byte_zero <= (cfg_r.cfg_byte_zero & ~`TCSR_CFG0_WMASK)
                  | (host_req.wdata & `TCSR_CFG0_WMASK);
            `TCSR_OFF_CFG1:
               cfg_r.cfg_byte_one <= (cfg_r.cfg_byte_one & ~`TCSR_CFG1_WMASK)
                  | (host_req.wdata & `TCSR_CFG1_WMASK);
            `TCSR_OFF_CFG2:
               cfg_r.cfg_byte_two <= (cfg_r.cfg_byte_two & ~`TCSR_CFG2_WMASK)
                  | (host_req.wdata & `TCSR_CFG2_WMASK);
            default:
               cfg_r <= cfg_r;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Chip status register
   // ----------------------------------------------------------------------------

   // Production flags; bus kind is taken only at initial load
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         chip_prod_r <= 2'h0;
      else if (ee_load)
      begin
         chip_prod_r[1] <= ee_image.mem_size_flag;
         chip_prod_r[0] <= ee_image.bus_kind_flag;
      end
      else if (set_default)
         chip_prod_r[1] <= image_hold_r.mem_size_flag;
   end

   // Permanent-disable flags from the image read at initialization
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         chip_kill_r <= 2'h0;
      else if (ee_load)
         chip_kill_r <= ee_image.chipkill;
      else if (set_default)
         chip_kill_r <= image_hold_r.chipkill;
   end

   // Authentication lock follows the failure counter; reserved bits zero
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         chip_low_r <= 4'h0;
      else
         chip_low_r <= {(auth_fail_counter >= AUTH_LIMIT_V), 3'h0};
   end

   // Status byte is only the concatenation of its flag registers, one driver each
   assign chip_status_r = {chip_prod_r, chip_kill_r, chip_low_r};

   // ----------------------------------------------------------------------------
   // Host read path
   // ----------------------------------------------------------------------------

   // Read mux: pure selection, nothing stored changes on a read
   always_comb
   begin
      case (host_req.addr)
         `TCSR_OFF_CFG0: rdata_nxt = cfg_r.cfg_byte_zero;
         `TCSR_OFF_CFG1: rdata_nxt = cfg_r.cfg_byte_one;
         `TCSR_OFF_CFG2: rdata_nxt = cfg_r.cfg_byte_two;
         `TCSR_OFF_RFST: rdata_nxt = rf_status_r & `TCSR_RFST_RMASK;
         `TCSR_OFF_CHST: rdata_nxt = chip_status_r & `TCSR_CHST_RMASK;
         default: rdata_nxt = `TCSR_UNMAPPED_DATA;
      endcase
   end

   // Registered read answer, one cycle after the request
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         host_rdata_r <= `TCSR_RST_BYTE;
         host_rvalid_r <= 1'b0;
      end
      else
      begin
         host_rvalid_r <= host_req.rd;
         if (host_req.rd)
            host_rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence s_host_wr(logic [5:0] a);
      wr_ok && host_req.addr == a;
   endsequence

   sequence s_field_steady;
      field_present [*3];
   endsequence

   AST_CFG0_RO: assert property (s_host_wr(`TCSR_OFF_CFG0) |=>
      cfg_r.cfg_byte_zero[7:4] == $past(cfg_r.cfg_byte_zero[7:4])
      && cfg_r.cfg_byte_zero[2:0] == $past(cfg_r.cfg_byte_zero[2:0]))
      else $error("cfg0 read-only bits changed on host write");

   AST_ARBIT_WR: assert property (s_host_wr(`TCSR_OFF_CFG0) |=>
      cfg_r.cfg_byte_zero[`TCSR_CFG0_ARBIT_BIT] == $past(host_req.wdata[3]))
      else $error("arbitration bit did not take host data");

   AST_LOAD: assert property (ee_load |=> cfg_r == $past(ee_image.cfg))
      else $error("configuration not loaded from EEPROM image");

   AST_CFG1_RO: assert property (s_host_wr(`TCSR_OFF_CFG1) |=> $stable(cfg_r.cfg_byte_one))
      else $error("cfg1 changed on host write");

   AST_CFG2_MASK: assert property (s_host_wr(`TCSR_OFF_CFG2) |=>
      cfg_r.cfg_byte_two == (($past(cfg_r.cfg_byte_two) & 8'h9C) | ($past(host_req.wdata) & 8'h63)))
      else $error("cfg2 write mask wrong");

   AST_FIELD: assert property (s_field_steady |=> ##1 rf_status_r[7])
      else $error("field flag not set after synchroniser delay");

   AST_STATE: assert property (!tag_state_upd |=> rf_status_r[6:3] == $past(tag_state))
      else $error("tag state not captured");

   AST_NOTVALID: assert property (tag_state_upd |=> rf_status_r[2] && $stable(rf_status_r[6:3]))
      else $error("update flag or state hold wrong");

   AST_BUSKIND_KEEP: assert property (set_default && !ee_load |=> $stable(chip_status_r[6]))
      else $error("bus kind changed on set-default");

   AST_KILL: assert property (ee_load |=> chip_status_r[5:4] == $past(ee_image.chipkill))
      else $error("disable flags not loaded");

   AST_AUTH: assert property (##1 chip_status_r[3] == $past(auth_fail_counter >= AUTH_LIMIT_V))
      else $error("auth lock flag wrong");

   AST_READ: assert property (host_req.rd && !host_req.wr && !ee_load && !set_default
      |=> $stable(cfg_r) ##0 host_rvalid_r)
      else $error("read disturbed configuration or no answer");

   AST_RESV: assert property (host_rvalid_r |->
      !($past(host_req.addr) == `TCSR_OFF_CHST && host_rdata_r[2:0] != 3'h0))
      else $error("reserved status bits read non-zero");

endmodule

/* sim/tcsr_host_model.sv */
// Host-side model issuing one-cycle register requests to the bank
module tcsr_host_model
   import tcsr_pkg::*;
(
   input wire logic clock,
   output tcsr_host_req_t host_req,
   input wire logic [7:0] host_rdata_r,
   input wire logic host_rvalid_r
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle request with no strobe and a scrambled address
   initial host_req = '{rd: 1'b0, wr: 1'b0, addr: 6'h2A, wdata: 8'h55};

   // ---------------------------------------------------------------------
   // Bus cycles
   // ---------------------------------------------------------------------
   // Write: strobe held one edge, then address and data scrambled on release
   task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clock);
      host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
      #1;
   endtask

   // Read: answer taken right after the edge that consumed the strobe
   task automatic read_reg(input logic [5:0] a, output logic [7:0] d, output logic v);
      @(posedge clock);
      host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clock);
      host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hA5};
      #1;
      d = host_rdata_r;
      v = host_rvalid_r;
   endtask
endmodule

/* sim/testbench.sv */
// Self-checking testbench of the tag config/status register bank
`include "tcsr_params.svh"
module testbench
   import tcsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ---------------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------------
   localparam tcsr_eeprom_t img_a = {8'hA5, 8'h5A, 8'hC3, 2'b10, 1'b1, 1'b1};
   logic clock;
   logic reset_n;
   tcsr_host_req_t host_req;
   logic [7:0] host_rdata_r;
   logic host_rvalid_r;
   logic ee_load;
   tcsr_eeprom_t ee_image;
   logic set_default;
   logic field_present;
   logic [3:0] tag_state;
   logic tag_state_upd;
   logic [2:0] auth_fail_counter;
   tcsr_cfg_t cfg_r;
   logic [7:0] rf_status_r;
   logic [7:0] chip_status_r;
   logic loaded_r;
   int fails;
   int tests_run;

   tcsr_regs #(.AUTH_W(3), .AUTH_LIMIT(7)) dut_u (
      .clock(clock), .reset_n(reset_n), .host_req(host_req),
      .host_rdata_r(host_rdata_r), .host_rvalid_r(host_rvalid_r),
      .ee_load(ee_load), .ee_image(ee_image), .set_default(set_default),
      .field_present(field_present), .tag_state(tag_state),
      .tag_state_upd(tag_state_upd), .auth_fail_counter(auth_fail_counter),
      .cfg_r(cfg_r), .rf_status_r(rf_status_r), .chip_status_r(chip_status_r),
      .loaded_r(loaded_r)
   );

   tcsr_host_model host_u (
      .clock(clock), .host_req(host_req),
      .host_rdata_r(host_rdata_r), .host_rvalid_r(host_rvalid_r)
   );

   // Free-running 100 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ---------------------------------------------------------------------
   // Checking helpers
   // ---------------------------------------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      host_u.read_reg(a, d, v);
      chk_byte({7'h00, v}, 8'h01);
      chk_byte(d, exp);
   endtask

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Advance n edges, then let their updates land
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // ---------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------
   task automatic t_before_load;
      rd_chk(`TCSR_OFF_CHST, 8'h00);
      host_u.write_reg(`TCSR_OFF_CFG2, 8'hFF);
      chk_byte(cfg_r.cfg_byte_two, 8'h00);
      chk_byte({7'h00, loaded_r}, 8'h00);
      $display("test before_load done, mismatches %0d", fails);
   endtask

   task automatic t_load;
      @(posedge clock);
      ee_load <= 1'b1;
      ee_image <= img_a;
      @(posedge clock);
      ee_load <= 1'b0;
      ee_image <= ~img_a;
      #1;
      chk_byte(cfg_r.cfg_byte_zero, 8'hA5);
      chk_byte(cfg_r.cfg_byte_one, 8'h5A);
      chk_byte(cfg_r.cfg_byte_two, 8'hC3);
      chk_byte({7'h00, loaded_r}, 8'h01);
      rd_chk(`TCSR_OFF_CFG0, 8'hA5);
      rd_chk(`TCSR_OFF_CFG1, 8'h5A);
      rd_chk(`TCSR_OFF_CFG2, 8'hC3);
      rd_chk(`TCSR_OFF_CHST, 8'hE0);
      $display("test load done, mismatches %0d", fails);
   endtask

   task automatic t_writes;
      logic [5:0] wa[7] = '{6'h01, 6'h01, 6'h02, 6'h03, 6'h03, 6'h05, 6'h04};
      logic [7:0] wd[7] = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF};
      logic [7:0] ex[7] = '{8'hAD, 8'hA5, 8'h5A, 8'hE3, 8'h80, 8'hE0, 8'h00};
      for (int i = 0; i < 7; i++)
      begin
         host_u.write_reg(wa[i], wd[i]);
         rd_chk(wa[i], ex[i]);
      end
      rd_chk(6'h3F, 8'h00);
      rd_chk(`TCSR_OFF_CFG2, 8'h80);
      rd_chk(`TCSR_OFF_CFG2, 8'h80);
      $display("test writes done, mismatches %0d", fails);
   endtask

   task automatic t_rf;
      logic [3:0] codes[11] = '{4'h0, 4'h1, 4'h3, 4'h2, 4'h6, 4'h7, 4'h9, 4'hB, 4'hA,
                                4'hE, 4'hF};
      foreach (codes[i])
      begin
         @(posedge clock);
         tag_state <= codes[i];
         settle(2);
         chk_byte(rf_status_r, {1'b0, codes[i], 3'b000});
      end
      @(posedge clock);
      field_present <= 1'b1;
      settle(3);
      chk_byte(rf_status_r, 8'hF8);
      @(posedge clock);
      tag_state <= 4'h6;
      tag_state_upd <= 1'b1;
      settle(1);
      chk_byte(rf_status_r, 8'hFC);
      @(posedge clock);
      tag_state_upd <= 1'b0;
      settle(2);
      chk_byte(rf_status_r, 8'hB0);
      rd_chk(`TCSR_OFF_RFST, 8'hB0);
      @(posedge clock);
      field_present <= 1'b0;
      settle(3);
      chk_byte(rf_status_r, 8'h30);
      $display("test rf_status done, mismatches %0d", fails);
   endtask

   task automatic t_setdef;
      host_u.write_reg(`TCSR_OFF_CFG0, 8'hFF);
      host_u.write_reg(`TCSR_OFF_CFG2, 8'hFF);
      @(posedge clock);
      set_default <= 1'b1;
      @(posedge clock);
      set_default <= 1'b0;
      #1;
      chk_byte(cfg_r.cfg_byte_zero, 8'hA5);
      chk_byte(cfg_r.cfg_byte_two, 8'hC3);
      rd_chk(`TCSR_OFF_CHST, 8'hE0);
      $display("test set_default done, mismatches %0d", fails);
   endtask

   task automatic t_auth;
      @(posedge clock);
      auth_fail_counter <= 3'd6;
      settle(2);
      rd_chk(`TCSR_OFF_CHST, 8'hE0);
      @(posedge clock);
      auth_fail_counter <= 3'd7;
      settle(2);
      rd_chk(`TCSR_OFF_CHST, 8'hE8);
      $display("test auth_lock done, mismatches %0d", fails);
   endtask

   // ---------------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------------
   initial
   begin
      reset_n = 1'b0;
      ee_load = 1'b0;
      ee_image = ~img_a;
      set_default = 1'b0;
      field_present = 1'b0;
      tag_state = 4'h0;
      tag_state_upd = 1'b0;
      auth_fail_counter = 3'd0;
      fails = 0;
      tests_run = 0;
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      t_before_load();
      t_load();
      t_writes();
      t_rf();
      t_setdef();
      t_auth();
      final_report();
   end

   // Cuts a hang short well after the expected 134 or so cycles
   initial
   begin
      #100us;
      fails++;
      $display("Error at %0t: watchdog expired", $time);
      final_report();
   end
endmodule
